// [pkg/hbw_pkg.sv]
// Constants and types shared by the host bus width and word swap logic.
// Assumes a single 100 MHz clock domain and an internal 32-bit register/FIFO side.
package hbw_pkg;

	// ------------------------------------------------------------------
	// Widths and encodings
	// ------------------------------------------------------------------
	localparam int HBW_DATA_W = 32;
	localparam int HBW_HALF_W = 16;
	localparam int HBW_ADDR_W = 8;
	localparam logic HBW_WIDTH_16 = 1'h0;
	localparam logic HBW_WIDTH_32 = 1'h1;
	localparam logic [31:0] HBW_SWAP_ALL_ONES = 32'hFFFFFFFF;
	localparam int HBW_CFG_WIDTH_BIT = 2;
	localparam logic [31:0] HBW_CFG_RESET = 32'h00000000;
	localparam logic [31:0] HBW_SWAP_RESET = 32'h00000000;
	// Strap age at which the second synchroniser flop first holds the pin.
	localparam logic [1:0] HBW_STRAP_SETTLE = 2'h2;

	// Half-word tracker: which half of the current word is held.
	typedef enum logic [1:0] {
		HBW_TRK_EMPTY,
		HBW_TRK_LOW,
		HBW_TRK_HIGH
	} hbw_trk_t;

endpackage : hbw_pkg

// [hw/hbw_tracker.sv]
// Half-word pairing tracker, one instance per transfer direction.
// Assumes accesses are single-cycle strobes from logic on the same clock.
`timescale 1ns/1ns
module hbw_tracker
	import hbw_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire logic strobe_i,
	input wire logic half_hi_i,
	input wire logic [hbw_pkg::HBW_ADDR_W-1:0] addr_i,
	output logic first_o,
	output logic complete_o,
	output logic repeat_o,
	output hbw_pkg::hbw_trk_t state_o
);
	import hbw_pkg::*;

	typedef struct packed {
		hbw_trk_t trk;
		logic [HBW_ADDR_W-1:0] addr;
	} hbw_trk_state_t;

	hbw_trk_state_t st_reg;
	hbw_trk_state_t st_next;

	// ------------------------------------------------------------------
	// Pairing decision
	// ------------------------------------------------------------------
	// A second access to the opposite half completes; a repeat of the
	// held half is flagged and the tracker restarts empty.
	always_comb begin
		st_next = st_reg;
		first_o = 1'b0;
		complete_o = 1'b0;
		repeat_o = 1'b0;
		if (clear_i) begin
			st_next.trk = HBW_TRK_EMPTY;
		end else if (strobe_i) begin
			unique case (st_reg.trk)
				HBW_TRK_EMPTY: begin
					first_o = 1'b1;
					st_next.trk = half_hi_i ? HBW_TRK_HIGH : HBW_TRK_LOW;
					st_next.addr = addr_i;
				end
				HBW_TRK_LOW, HBW_TRK_HIGH: begin
					if (half_hi_i == (st_reg.trk == HBW_TRK_HIGH)) begin
						repeat_o = 1'b1;
					end else begin
						complete_o = 1'b1;
					end
					st_next.trk = HBW_TRK_EMPTY;
				end
				default: begin
					st_next.trk = HBW_TRK_EMPTY;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '{trk: HBW_TRK_EMPTY, addr: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign state_o = st_reg.trk;

endmodule : hbw_tracker

// [hw/hbw_host_port.sv]
// Host data port: 32/16-bit width strap, half-word pairing and word swap.
// Assumes host strobes are already synchronous to ref_clk_i and one cycle long;
// the width strap pin is asynchronous and is synchronised here.
`timescale 1ns/1ns
module hbw_host_port
	import hbw_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic bus_width_strap_pin_i,
	input wire logic [31:0] word_swap_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic half_word_select_line_i,
	input wire logic [hbw_pkg::HBW_ADDR_W-1:0] host_addr_i,
	input wire logic [31:0] host_wdata_i,
	input wire logic [31:0] int_rdata_i,
	output logic [31:0] host_rdata_o,
	output logic [31:0] host_rdata_oe_o,
	output logic int_wr_o,
	output logic int_rd_o,
	output logic [hbw_pkg::HBW_ADDR_W-1:0] int_addr_o,
	output logic [31:0] int_wdata_o,
	output logic wr_discard_o,
	output logic rd_invalid_o,
	output logic [31:0] hardware_config_register_o
);
	import hbw_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic strap_meta;
		logic strap_sync;
		logic [1:0] strap_age;
		logic width32;
		logic [31:0] cfg;
		logic [15:0] wr_hold;
		logic [31:0] rd_word;
		logic [31:0] rdata;
		logic [31:0] rdata_oe;
		logic int_wr;
		logic int_rd;
		logic [HBW_ADDR_W-1:0] int_addr;
		logic [31:0] int_wdata;
		logic wr_discard;
		logic rd_invalid;
	} hbw_port_state_t;

	hbw_port_state_t st_reg;
	hbw_port_state_t st_next;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// Pairing two host halves into one internal word only works when the
	// internal word is exactly two halves wide and holds the width bit.
	if (HBW_DATA_W != 2 * HBW_HALF_W || HBW_CFG_WIDTH_BIT >= HBW_DATA_W) begin : g_width_check
		$error("internal word must be two host halves wide");
	end

	logic swap_on;
	logic half_hi;
	logic wr_first;
	logic wr_done;
	logic wr_rep;
	logic rd_first;
	logic rd_done;
	logic rd_rep;
	logic [15:0] rd_half;

	// ------------------------------------------------------------------
	// Lane mapping
	// ------------------------------------------------------------------
	// Swap only counts in 16-bit mode and only for the all-ones value.
	assign swap_on = !st_reg.width32 && (word_swap_i == HBW_SWAP_ALL_ONES);
	// Internal half addressed by this access; used for registers and FIFOs alike.
	assign half_hi = half_word_select_line_i ^ swap_on;

	// ------------------------------------------------------------------
	// Per-direction trackers
	// ------------------------------------------------------------------
	// Trackers are held clear in 32-bit mode so no stale half survives a
	// width change.
	hbw_tracker u_wr_trk (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.clear_i(st_reg.width32),
		.strobe_i(host_wr_i),
		.half_hi_i(half_hi),
		.addr_i(host_addr_i),
		.first_o(wr_first),
		.complete_o(wr_done),
		.repeat_o(wr_rep),
		.state_o()
	);

	hbw_tracker u_rd_trk (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.clear_i(st_reg.width32),
		.strobe_i(host_rd_i),
		.half_hi_i(half_hi),
		.addr_i(host_addr_i),
		.first_o(rd_first),
		.complete_o(rd_done),
		.repeat_o(rd_rep),
		.state_o()
	);

	// Half of the word fetched on the first read, picked by internal half.
	assign rd_half = half_hi ? st_reg.rd_word[31:16] : st_reg.rd_word[15:0];

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.int_wr = 1'b0;
		st_next.int_rd = 1'b0;
		st_next.wr_discard = 1'b0;
		st_next.rd_invalid = 1'b0;
		// Strap passes two flops before anything reads it.
		st_next.strap_meta = bus_width_strap_pin_i;
		st_next.strap_sync = st_reg.strap_meta;
		// Width is latched once after reset release; a live strap change is ignored.
		// The age counter waits until the second flop holds the pin, since the
		// reset value of that flop would otherwise always pick 16-bit mode.
		if (st_reg.strap_age != 2'h3) begin
			st_next.strap_age = st_reg.strap_age + 2'h1;
		end
		if (st_reg.strap_age == HBW_STRAP_SETTLE) begin
			st_next.width32 = st_reg.strap_sync;
			st_next.cfg = HBW_CFG_RESET;
			st_next.cfg[HBW_CFG_WIDTH_BIT] = st_reg.strap_sync;
		end
		if (st_reg.width32) begin
			// Whole word per access, lanes mapped straight through.
			st_next.rdata_oe = '1;
			if (host_wr_i) begin
				st_next.int_wr = 1'b1;
				st_next.int_addr = host_addr_i;
				st_next.int_wdata = host_wdata_i;
			end
			if (host_rd_i) begin
				st_next.int_rd = 1'b1;
				st_next.int_addr = host_addr_i;
				st_next.rdata = int_rdata_i;
			end
		end else begin
			// Upper lanes never driven in 16-bit mode.
			st_next.rdata_oe = 32'h0000FFFF;
			if (wr_first) begin
				st_next.wr_hold = host_wdata_i[15:0];
			end
			if (wr_done) begin
				// Held half and new half land in their internal halves, so the
				// low half always sits in bits 15:0 whichever half arrives first.
				st_next.int_wr = 1'b1;
				st_next.int_addr = host_addr_i;
				st_next.int_wdata = half_hi ? {host_wdata_i[15:0], st_reg.wr_hold}
					: {st_reg.wr_hold, host_wdata_i[15:0]};
			end
			// A repeat also drops the held half, so the host must resend both
			// halves; this keeps a stale half from pairing with a later word.
			st_next.wr_discard = wr_rep;
			if (rd_first) begin
				// One internal read per word; the second half comes from the copy.
				st_next.int_rd = 1'b1;
				st_next.int_addr = host_addr_i;
				st_next.rd_word = int_rdata_i;
				st_next.rdata = {16'h0000, half_hi ? int_rdata_i[31:16] : int_rdata_i[15:0]};
			end
			if (rd_done) begin
				st_next.rdata = {16'h0000, rd_half};
			end
			if (rd_rep) begin
				st_next.rdata = {16'h0000, rd_half};
				st_next.rd_invalid = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Every output is a register field, never a decoded net.
	assign host_rdata_o = st_reg.rdata;
	assign host_rdata_oe_o = st_reg.rdata_oe;
	assign int_wr_o = st_reg.int_wr;
	assign int_rd_o = st_reg.int_rd;
	assign int_addr_o = st_reg.int_addr;
	assign int_wdata_o = st_reg.int_wdata;
	assign wr_discard_o = st_reg.wr_discard;
	assign rd_invalid_o = st_reg.rd_invalid;
	assign hardware_config_register_o = st_reg.cfg;

endmodule : hbw_host_port

// [testbench/hbw_host_port_props.sv]
// Concurrent checks on the host data port outputs.
// Assumes it is bound to hbw_host_port and sees only that module's ports.
`timescale 1ns/1ns
module hbw_host_port_props
	import hbw_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [31:0] host_wdata_i,
	input wire logic [31:0] int_rdata_i,
	input wire logic [31:0] host_rdata_o,
	input wire logic [31:0] host_rdata_oe_o,
	input wire logic int_wr_o,
	input wire logic int_rd_o,
	input wire logic [31:0] int_wdata_o,
	input wire logic wr_discard_o,
	input wire logic rd_invalid_o,
	input wire logic [31:0] hardware_config_register_o
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	// The width bit is taken from the config output, which is set once after reset release and then stays fixed.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic w32 = hardware_config_register_o[HBW_CFG_WIDTH_BIT];
	chk_cfg_only_width: assert property ((hardware_config_register_o & 32'hFFFFFFFB) == 32'h00000000)
		else $error("config has stray bits");
	chk_upper_undriven: assert property (!w32 |-> host_rdata_oe_o[31:16] == 16'h0000 && host_rdata_o[31:16] == 16'h0000)
		else $error("upper lines driven in narrow mode");
	chk_wide_oe: assert property (w32 && $past(w32) |-> host_rdata_oe_o == 32'hFFFFFFFF)
		else $error("wide mode lines not driven");
	chk_full_write: assert property (w32 && host_wr_i |=> int_wr_o && int_wdata_o == $past(host_wdata_i))
		else $error("wide write not passed whole");
	chk_full_read: assert property (w32 && host_rd_i |=> int_rd_o && host_rdata_o == $past(int_rdata_i))
		else $error("wide read not passed whole");
	chk_wr_cause: assert property (int_wr_o |-> $past(host_wr_i))
		else $error("commit without host write");
	chk_rd_cause: assert property (int_rd_o |-> $past(host_rd_i))
		else $error("fetch without host read");
	chk_discard_nowr: assert property (wr_discard_o |-> !int_wr_o && !w32 && $past(host_wr_i))
		else $error("discarded write committed");
	chk_invalid_rd: assert property (rd_invalid_o |-> !int_rd_o && !w32 && $past(host_rd_i))
		else $error("bad invalid read flag");
endmodule : hbw_host_port_props

bind hbw_host_port hbw_host_port_props u_hbw_host_port_props(.ref_clk_i, .rstn_i, .host_wr_i, .host_rd_i,
	.host_wdata_i, .int_rdata_i, .host_rdata_o, .host_rdata_oe_o, .int_wr_o, .int_rd_o, .int_wdata_o,
	.wr_discard_o, .rd_invalid_o, .hardware_config_register_o);

// [testbench/hbw_host_mem_model.sv]
// Internal word store standing behind the host data port.
// Assumes a combinational read and a one-cycle commit pulse from the port.
`timescale 1ns/1ns
module hbw_host_mem_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rd_addr_i,
	output logic [31:0] rd_data_o,
	input wire logic wr_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [31:0] wr_data_i
);
	// Words start from their address so a read can be predicted without peeking here.
	logic [31:0] mem [256];
	initial for (int i = 0; i < 256; i++) mem[i] = {8'hC3, 8'(i), 8'h5A, 8'(i)};
	assign rd_data_o = mem[rd_addr_i];
	always @(posedge ref_clk_i) if (wr_i) mem[wr_addr_i] <= wr_data_i;
endmodule : hbw_host_mem_model

// [testbench/testbench.sv]
// Self-checking bench for the host data port in both bus widths.
// Assumes a 100 MHz clock and the internal word store model.
`timescale 1ns/1ns
module testbench;
	import hbw_pkg::*;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, strap = 1'b1, wr = 1'b0, rd = 1'b0, a1 = 1'b0, iwr, ird, disc, inv;
	logic [7:0] addr = 8'h00, iaddr;
	logic [31:0] swap = 32'h00000000, wdata = 32'h00000000, mrd, rdata, oe, iwd, cfg;
	logic [31:0] sws [3] = '{32'h00000000, 32'hFFFFFFFF, 32'hFFFF0000};
	int errors = 0, tests_run = 0;
	initial forever #5 ref_clk_i = ~ref_clk_i;
	hbw_host_port u_hbw_host_port(.ref_clk_i, .rstn_i, .bus_width_strap_pin_i(strap), .word_swap_i(swap),
		.host_wr_i(wr), .host_rd_i(rd), .half_word_select_line_i(a1), .host_addr_i(addr), .host_wdata_i(wdata),
		.int_rdata_i(mrd), .host_rdata_o(rdata), .host_rdata_oe_o(oe), .int_wr_o(iwr), .int_rd_o(ird),
		.int_addr_o(iaddr), .int_wdata_o(iwd), .wr_discard_o(disc), .rd_invalid_o(inv),
		.hardware_config_register_o(cfg));
	hbw_host_mem_model u_hbw_host_mem_model(.ref_clk_i, .rd_addr_i(addr), .rd_data_o(mrd), .wr_i(iwr),
		.wr_addr_i(iaddr), .wr_data_i(iwd));
	function automatic logic [31:0] mw(input logic [7:0] a);
		return {8'hC3, a, 8'h5A, a};
	endfunction : mw
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	// One strobe, raised and dropped on falling edges so exactly one rising edge takes it.
	task automatic acc(input logic w, input logic h, input logic [7:0] a, input logic [31:0] d);
		@(negedge ref_clk_i);
		wr = w;
		rd = !w;
		a1 = h;
		addr = a;
		wdata = d;
		@(negedge ref_clk_i);
		wr = 1'b0;
		rd = 1'b0;
	endtask : acc
	task automatic boot(input logic s);
		rstn_i = 1'b0;
		strap = s;
		repeat (8) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		chk(cfg, {29'h0, s, 2'h0}, "cfg");
	endtask : boot
	// Pulses stand for one cycle only, so each check runs on the falling edge
	// that ends the strobe, right after the edge that answered it.
	task automatic t_wide();
		boot(1'b1);
		swap = 32'hFFFFFFFF;
		acc(1'b1, 1'b1, 8'h21, 32'hDEADBEEF);
		chk(iwr, 1'h1, "wide commit");
		chk(iwd, 32'hDEADBEEF, "wide wdata");
		acc(1'b0, 1'b1, 8'h90, 32'h00000000);
		chk(ird, 1'h1, "wide fetch");
		chk(rdata, mw(8'h90), "wide rdata");
		chk(oe, 32'hFFFFFFFF, "wide oe");
		$display("test wide done");
	endtask : t_wide
	task automatic t_pair_wr(input logic [31:0] sw, input logic f);
		logic s;
		s = (sw === HBW_SWAP_ALL_ONES);
		swap = sw;
		acc(1'b1, f, 8'h30, 32'hFFFF1234);
		chk(iwr, 1'h0, "half held");
		acc(1'b1, !f, 8'h30, 32'hFFFFABCD);
		chk(iwr, 1'h1, "pair commit");
		chk(iaddr, 8'h30, "pair addr");
		chk(iwd, (f == s) ? 32'hABCD1234 : 32'h1234ABCD, "pair wdata");
		$display("test pair write done");
	endtask : t_pair_wr
	task automatic t_pair_rd(input logic [31:0] sw, input logic f);
		logic s;
		logic [31:0] w;
		s = (sw === HBW_SWAP_ALL_ONES);
		swap = sw;
		w = mw(8'h88);
		acc(1'b0, f, 8'h88, 32'h00000000);
		chk(ird, 1'h1, "fetch");
		chk(rdata, {16'h0, (f ^ s) ? w[31:16] : w[15:0]}, "first half");
		chk(oe, 32'h0000FFFF, "narrow oe");
		acc(1'b0, !f, 8'h88, 32'h00000000);
		chk(ird, 1'h0, "no second fetch");
		chk(rdata, {16'h0, (f ^ s) ? w[15:0] : w[31:16]}, "second half");
		$display("test pair read done");
	endtask : t_pair_rd
	task automatic t_repeat();
		swap = 32'h00000000;
		strap = 1'b1;
		acc(1'b1, 1'b0, 8'h40, 32'h00001111);
		acc(1'b1, 1'b0, 8'h40, 32'h00002222);
		chk({disc, iwr}, 2'h2, "discard");
		acc(1'b0, 1'b1, 8'h88, 32'h00000000);
		acc(1'b0, 1'b1, 8'h88, 32'h00000000);
		chk(inv, 1'h1, "invalid");
		acc(1'b0, 1'b0, 8'h88, 32'h00000000);
		chk(ird, 1'h1, "fresh fetch");
		chk(cfg, 32'h00000000, "strap change ignored");
		$display("test repeat done");
	endtask : t_repeat
	task automatic finish_test();
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// Wide mode first, then narrow mode over every swap setting and both half orders.
	initial begin
		t_wide();
		boot(1'b0);
		for (int i = 0; i < 6; i++) begin
			t_pair_wr(sws[i / 2], i[0]);
			t_pair_rd(sws[i / 2], i[0]);
		end
		t_repeat();
		finish_test();
	end
endmodule : testbench
